// ### sim/eps_host_model.sv
// Host side of the event pin: resolves the wire and counts pulses.
// Assumes a strap level holds the pin while the block releases it.
`timescale 1ns/1ps
module eps_host_model (
    input wire logic event_pin_n_out,
    input wire logic event_pin_oe_out,
    input wire logic cfg_lvl_in,
    output logic pin_lvl_out,
    output int pulse_cnt
);
    // Wire level from the push/pull stage or the strap
    assign pin_lvl_out = event_pin_oe_out ? event_pin_n_out : cfg_lvl_in;
    // Count falling edges while the block drives
    initial pulse_cnt = 0;
    always @(negedge pin_lvl_out) if (event_pin_oe_out) pulse_cnt++;
endmodule : eps_host_model

// ### sim/eps_signaller_sva.sv
// Checker on the event pulse signaller ports.
// Assumes eps_pkg timing constants; bound onto eps_signaller.
`timescale 1ns/1ps
module eps_signaller_sva (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] mode_in,
    input wire logic [7:0] wake_status_reg_a_in,
    input wire logic [7:0] wake_en_a_in,
    input wire logic event_pin_n_out,
    input wire logic event_pin_oe_out,
    input wire logic status_update_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    int lo_q, hi_q;
    // Cycles spent low and high on the pin
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            lo_q <= 0;
            hi_q <= 9000;
        end else begin
            lo_q <= event_pin_n_out ? 0 : lo_q + 1;
            hi_q <= event_pin_n_out ? hi_q + 1 : 0;
        end
    end
    sequence s_new_wake;
        $rose(|(wake_status_reg_a_in & wake_en_a_in)) && mode_in == eps_pkg::MODE_NORMAL && hi_q > 4100;
    endsequence
    a_pulse_width: assert property ($rose(event_pin_n_out) |-> lo_q == eps_pkg::PULSE_CYC)
        else $error("pulse width wrong");
    a_gap_min: assert property ($fell(event_pin_n_out) |-> hi_q >= eps_pkg::GAP_CYC)
        else $error("gap too short");
    a_wake_start: assert property (s_new_wake |-> ##[1:3] status_update_out)
        else $error("wake event not signalled");
    a_update_then_low: assert property (status_update_out |=> !event_pin_n_out)
        else $error("pin not low after update");
    a_fall_has_update: assert property ($fell(event_pin_n_out) |-> $past(status_update_out))
        else $error("fall without update");
    a_update_after_gap: assert property (status_update_out |-> hi_q >= eps_pkg::GAP_CYC)
        else $error("update inside gap");
    a_init_released: assert property (mode_in == eps_pkg::MODE_INIT |-> !event_pin_oe_out)
        else $error("pin driven in init");
    a_init_quiet: assert property (mode_in == eps_pkg::MODE_INIT |-> !status_update_out)
        else $error("pulse started in init");
endmodule : eps_signaller_sva
bind eps_signaller eps_signaller_sva eps_signaller_sva_i (.clk_in, .rstn_in, .mode_in, .wake_status_reg_a_in,
    .wake_en_a_in, .event_pin_n_out, .event_pin_oe_out, .status_update_out);

// ### sim/test_event_pulse_signaller.sv
// Self-checking bench for the event pulse signaller.
// Assumes the host model and the bound checker.
`timescale 1ns/1ps
module test_event_pulse_signaller;
    logic clk_in = 0, rstn_in = 0, cls = 0, stp = 0, cfg = 1, pin, pin_n, oe, cfg_o, cfg_v;
    logic [2:0] mode = eps_pkg::MODE_NORMAL;
    logic [7:0] wa = 8'h00, wb = 8'h00, ea = 8'h00;
    logic [15:0] ff = 16'h0000, fx = 16'h0000;
    int pulse_cnt, num_errors = 0, check_count = 0, cyc = 0;
    initial forever #12.5 clk_in = ~clk_in;
    eps_signaller eps_signaller_i (.clk_in, .rstn_in, .mode_in(mode), .class_global_in(cls),
        .wake_status_reg_a_in(wa), .wake_status_reg_b_in(wb), .wake_en_a_in(ea), .wake_en_b_in(8'h00),
        .fail_flags_in(ff), .fail_excluded_in(fx), .stop_cmd_in(stp), .event_pin_in(pin), .event_pin_n_out(pin_n),
        .event_pin_oe_out(oe), .status_update_out(), .hw_config_out(cfg_o), .hw_config_valid_out(cfg_v));
    eps_host_model eps_host_model_i (.event_pin_n_out(pin_n), .event_pin_oe_out(oe), .cfg_lvl_in(cfg),
        .pin_lvl_out(pin), .pulse_cnt);
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wt(input int n);
        repeat (n) @(negedge clk_in);
    endtask : wt
    task finish_test;
        $display("checks=%0d errors=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : finish_test
    // Cut a hang short
    always @(posedge clk_in) if (++cyc == 50000) begin num_errors++; finish_test; end
    // Scenarios in sequence
    initial begin
        wt(5);
        rstn_in = 1;
        ea = 8'h05; wa = 8'h02; wt(200);
        chk(16'(pulse_cnt), 16'h0000);
        wa = 8'h03; wt(100); wa = 8'h07; wt(100);
        chk(16'(pulse_cnt), 16'h0001);
        wt(16500);
        chk(16'(pulse_cnt), 16'h0002);
        wa = 8'h00;
        $display("wake test done");
        ff = 16'h0004; wt(200);
        chk(16'(pulse_cnt), 16'h0002);
        ff = 16'h0000; cls = 1; fx = 16'h0010; wt(2); ff = 16'h0010; wt(200);
        chk(16'(pulse_cnt), 16'h0002);
        ff = 16'h0018; wt(8500);
        chk(16'(pulse_cnt), 16'h0003);
        ff = 16'h0000; cls = 0; $display("fail test done");
        wb = 8'h10; wt(200);
        chk(16'(pulse_cnt), 16'h0003);
        stp = 1; wt(1); stp = 0; mode = eps_pkg::MODE_STOP; wt(8500);
        chk(16'(pulse_cnt), 16'h0004);
        wb = 8'h00; $display("stop test done");
        mode = eps_pkg::MODE_INIT; cfg = 0; wt(500);
        chk(16'({oe, cfg_v, cfg_o}), 16'h0002);
        $display("init test done");
        finish_test;
    end
endmodule : test_event_pulse_signaller

// ### src/eps_pkg.sv
// Constants for the event pulse signaller: timing figures and derived cycle counts.
// Assumes a single 40 MHz clock; status registers live outside and are cleared by the host.
// Functional notes
// - In Normal or Stop mode a qualified event drives the pin low for 100 us.
// - Keep the pin high at least 100 us between consecutive pulses.
// - Pulses never change the operating mode by themselves.
// - Class bit 0 selects wake only, 1 adds failure events; reset 0.
// - Wake class pulses only for wake bits whose source is enabled; the stop command check here also counts bits whose source is disabled.
// - Wide class also pulses on failure flags; wake level status never pulses.
// - Restart or fail-safe errors, power-on reset and device status never pulse.
// - Entering Stop mode with wake status bits still set raises a pulse.
// - Status registers update at each falling edge of the pulse.
// - Events stay latched until the host clears; wake level status is unlatched.
// - In Init mode the pin is a configuration input, filtered 10 us.
// - Wide class pulses use the same timing and latching as wake class.
package eps_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    // Pulse width, typical 100 us
    localparam int unsigned PULSE_WIDTH_US = 100;
    // Minimum high time between pulses, typical 100 us
    localparam int unsigned PULSE_GAP_TIME_US = 100;
    // Configuration select filter, typical 10 us
    localparam int unsigned CFG_FILTER_US = 10;
    localparam int unsigned PULSE_CYC = (CLK_HZ / 1_000_000) * PULSE_WIDTH_US;
    localparam int unsigned GAP_CYC = (CLK_HZ / 1_000_000) * PULSE_GAP_TIME_US;
    localparam int unsigned CFG_CYC = (CLK_HZ / 1_000_000) * CFG_FILTER_US;
    localparam int unsigned CNT_W = 13;
    // Reset value of the class select bit
    localparam logic CLASS_RESET = 1'b0;
    // Operating mode codes at the mode input
    localparam logic [2:0] MODE_INIT = 3'h0;
    localparam logic [2:0] MODE_NORMAL = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_OTHER = 3'h3;
endpackage : eps_pkg

// ### src/eps_signaller.sv
// Event pulse signaller: active-low push/pull event pin with Init-mode config sampling.
// Assumes status flags arrive already latched from the status register block on clk_in.
`timescale 1ns/1ps
module eps_signaller #(
    parameter int unsigned WAKE_A_W = 8,
    parameter int unsigned WAKE_B_W = 8,
    parameter int unsigned FAIL_W = 16
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] mode_in,
    input wire logic class_global_in,
    input wire logic [WAKE_A_W-1:0] wake_status_reg_a_in,
    input wire logic [WAKE_B_W-1:0] wake_status_reg_b_in,
    input wire logic [WAKE_A_W-1:0] wake_en_a_in,
    input wire logic [WAKE_B_W-1:0] wake_en_b_in,
    input wire logic [FAIL_W-1:0] fail_flags_in,
    input wire logic [FAIL_W-1:0] fail_excluded_in,
    input wire logic stop_cmd_in,
    input wire logic event_pin_in,
    output logic event_pin_n_out,
    output logic event_pin_oe_out,
    output logic status_update_out,
    output logic hw_config_out,
    output logic hw_config_valid_out
);
    typedef enum logic [2:0] {
        EPS_IDLE = 3'b001,
        EPS_LOW = 3'b010,
        EPS_GAP = 3'b100
    } eps_state_t;

    eps_state_t state_q, state_d;
    logic [12:0] cnt_q, cnt_d;
    logic [FAIL_W+WAKE_A_W+WAKE_B_W-1:0] seen_q, seen_d;
    logic pend_q, pend_d;
    logic pin_s1_q, pin_s2_q;
    logic [8:0] flt_q, flt_d;
    logic cfg_q, cfg_d, cfg_v_q, cfg_v_d;
    logic active_mode, init_mode;
    logic [FAIL_W+WAKE_A_W+WAKE_B_W-1:0] qual;
    logic new_event, stop_trig;

    // Qualify sources by class and enable
    always_comb begin
        active_mode = (mode_in == eps_pkg::MODE_NORMAL) || (mode_in == eps_pkg::MODE_STOP);
        init_mode = (mode_in == eps_pkg::MODE_INIT);
        qual = {fail_flags_in & ~fail_excluded_in & {FAIL_W{class_global_in}},
                wake_status_reg_a_in & wake_en_a_in,
                wake_status_reg_b_in & wake_en_b_in};
        new_event = |(qual & ~seen_q);
        stop_trig = stop_cmd_in && ((|wake_status_reg_a_in) || (|wake_status_reg_b_in));
    end

    // Pulse sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        seen_d = seen_q & qual;
        pend_d = pend_q || ((new_event || stop_trig) && active_mode);
        status_update_out = 1'b0;
        unique case (state_q)
            EPS_IDLE: begin
                if (pend_q && active_mode) begin
                    state_d = EPS_LOW;
                    cnt_d = 13'(eps_pkg::PULSE_CYC - 1);
                    // Everything qualified now is captured in seen_d, so nothing stays pending
                    pend_d = 1'b0;
                    seen_d = qual;
                end
            end
            EPS_LOW: begin
                if (cnt_q == 13'h0000) begin
                    state_d = EPS_GAP;
                    cnt_d = 13'(eps_pkg::GAP_CYC - 1);
                end else begin
                    cnt_d = cnt_q - 13'h0001;
                end
            end
            EPS_GAP: begin
                if (cnt_q == 13'h0000) begin
                    state_d = EPS_IDLE;
                end else begin
                    cnt_d = cnt_q - 13'h0001;
                end
            end
        endcase
        // Strobe the status block on the falling edge of the pin
        status_update_out = (state_q == EPS_IDLE) && (state_d == EPS_LOW);
    end

    // Config filter: level must hold for the filter time
    always_comb begin
        flt_d = flt_q;
        cfg_d = cfg_q;
        cfg_v_d = cfg_v_q;
        if (init_mode) begin
            if (pin_s2_q != cfg_q) begin
                if (flt_q == 9'(eps_pkg::CFG_CYC - 1)) begin
                    cfg_d = pin_s2_q;
                    flt_d = 9'h000;
                end else begin
                    flt_d = flt_q + 9'h001;
                end
            end else begin
                flt_d = 9'h000;
                if (flt_q == 9'h000) begin
                    cfg_v_d = 1'b1;
                end
            end
        end
    end

    // Registers
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_q <= EPS_IDLE;
            cnt_q <= 13'h0000;
            seen_q <= '0;
            pend_q <= 1'b0;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            flt_q <= 9'h000;
            cfg_q <= 1'b1;
            cfg_v_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            seen_q <= seen_d;
            pend_q <= pend_d;
            pin_s1_q <= event_pin_in;
            pin_s2_q <= pin_s1_q;
            flt_q <= flt_d;
            cfg_q <= cfg_d;
            cfg_v_q <= cfg_v_d;
        end
    end

    // Pin drive: released in Init mode so the config level can be read; mode untouched
    always_comb begin
        event_pin_oe_out = !init_mode;
        event_pin_n_out = !(state_q == EPS_LOW);
        hw_config_out = cfg_q;
        hw_config_valid_out = cfg_v_q;
    end
endmodule : eps_signaller
